/* File: src/sso_pkg.sv */
package sso_pkg;
	localparam int           DW             = 16;
	localparam int           OPW            = 7;
	localparam int           STACK_DEPTH    = 16;
	localparam int           SPW            = 4;
	localparam logic [6:0]   OP_NOP         = 7'h00;
	localparam logic [6:0]   OP_PUSH_SR     = 7'h21;
	localparam logic [6:0]   OP_POP_SR      = 7'h22;
	localparam logic [6:0]   OP_READ_SR     = 7'h2e;
	localparam logic [6:0]   OP_WRITE_SR    = 7'h1c;
	localparam logic [6:0]   OP_WIDTH_FULL  = 7'h24;
	localparam logic [6:0]   OP_WIDTH_TWELVE = 7'h27;
	localparam logic [6:0]   OP_WIDTH_BYTE  = 7'h26;
	localparam logic [6:0]   OP_HOLD_MODE   = 7'h25;
	localparam logic [6:0]   OP_IDLE        = 7'h10;
	localparam logic [6:0]   OP_DISABLE_INT = 7'h16;
	localparam logic [6:0]   OP_ENABLE_INT  = 7'h36;
	localparam logic [6:0]   OP_CLEAR_INT   = 7'h01;
	localparam logic [2:0]   OP_REL_JUMP_HI = 3'h7;
	localparam logic [1:0]   OP_REL_DATA_LO = 2'h1;
	localparam logic [1:0]   OP_REL_CALL_LO = 2'h2;
	localparam int           SR_WID_HI      = 5;
	localparam int           SR_WID_LO      = 4;
	localparam int           SR_INT_DIS     = 2;
	localparam int           SR_SIGN        = 1;
	localparam int           SR_MASK_LO     = 6;
	localparam int           NUM_IRQ        = 10;
	localparam logic [1:0]   WID_FULL       = 2'h0;
	localparam logic [1:0]   WID_BYTE       = 2'h1;
	localparam logic [1:0]   WID_HOLD       = 2'h2;
	localparam logic [1:0]   WID_TWELVE     = 2'h3;
	localparam logic [15:0]  SR_RESET       = 16'hffc4;
	localparam logic [15:0]  PC_RESET       = 16'h0000;
	localparam logic [3:0]   SP_RESET       = 4'h0;
	typedef enum logic [1:0] {
		SSO_RUN   = 2'b00,
		SSO_IDLE  = 2'b01,
		SSO_AFTER = 2'b11
	} sso_phase_t;
endpackage : sso_pkg

/* File: src/sso_offset_ext.sv */
`timescale 1ns/1ps
module sso_offset_ext
	import sso_pkg::*;
(
	input  wire logic [1:0]  i_width,
	input  wire logic [15:0] i_data,
	output logic [15:0]      o_offset
);
	// hold mode shares the byte width
	always_comb
	begin
		case (i_width)
			WID_FULL:   o_offset = i_data;
			WID_TWELVE: o_offset = {{4{i_data[11]}}, i_data[11:0]};
			default:    o_offset = {{8{i_data[7]}}, i_data[7:0]};
		endcase
	end
endmodule : sso_offset_ext

/* File: src/sso_core.sv */
`timescale 1ns/1ps
module sso_core
	import sso_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
)(
	input  wire logic               i_ref_clk,
	input  wire logic               i_nrst,
	input  wire logic [OPW-1:0]     i_instr,
	input  wire logic [DW-1:0]      i_data,
	input  wire logic [NUM_IRQ-1:0] i_irq,
	input  wire logic               i_vector_valid,
	input  wire logic [DW-1:0]      i_vector,
	input  wire logic               i_flag,
	output logic [DW-1:0]           o_data,
	output logic                    o_data_oe,
	output logic [DW-1:0]           o_addr,
	output logic                    o_addr_oe,
	output logic                    o_in_progress,
	output logic [DW-1:0]           o_status,
	output logic [SPW-1:0]          o_stack_ptr
);
	typedef struct packed {
		logic [OPW-1:0]     instr;
		logic [DW-1:0]      pc;
		logic [DW-1:0]      sr;
		logic [SPW-1:0]     sp;
		logic [NUM_IRQ-1:0] pend;
		logic               in_prog;
		logic               svc_first;
		logic [DW-1:0]      ret_addr;
		sso_phase_t         phase;
		logic [DW-1:0]      addr;
		logic               addr_oe;
		logic [DW-1:0]      dout;
		logic               dout_oe;
	} sso_state_t;

	sso_state_t       st_q;
	sso_state_t       st_d;
	logic [DW-1:0]    stack_q [DEPTH];
	logic             push_en;
	logic [SPW-1:0]   push_idx;
	logic [DW-1:0]    push_val;
	logic [DW-1:0]    offset;
	logic [DW-1:0]    pc_inc;
	logic [NUM_IRQ-1:0] live;

	function automatic logic [SPW-1:0] sp_step(input logic [SPW-1:0] sp, input logic up);
		sp_step = up ? SPW'(sp + 1'b1) : SPW'(sp - 1'b1);
	endfunction : sp_step

	// jump condition field: unconditional, not flag, flag, sign
	function automatic logic cond_met(input logic [1:0] cc, input logic flag, input logic sign);
		case (cc)
			2'h0:    cond_met = 1'b1;
			2'h1:    cond_met = !flag;
			2'h2:    cond_met = flag;
			default: cond_met = sign;
		endcase
	endfunction : cond_met

	sso_offset_ext u_ext (
		.i_width  (st_q.sr[SR_WID_HI:SR_WID_LO]),
		.i_data   (i_data),
		.o_offset (offset)
	);

	assign pc_inc = DW'(st_q.pc + 1'b1);
	assign live = st_q.pend & ~st_q.sr[SR_MASK_LO +: NUM_IRQ];

	always_comb
	begin
		st_d = st_q;
		push_en = 1'b0;
		push_idx = st_q.sp;
		push_val = st_q.sr;
		st_d.instr = i_instr;
		st_d.dout_oe = 1'b0;
		st_d.addr_oe = 1'b1;
		st_d.pend = st_q.pend | i_irq;
		st_d.pc = pc_inc;
		st_d.addr = pc_inc;
		st_d.phase = SSO_RUN;
		st_d.svc_first = 1'b0;
		if (st_q.svc_first)
		begin
			// the opcode latched in the accept cycle is dropped, not executed, while the return address is pushed
			st_d.sp = sp_step(st_q.sp, 1'b1);
			push_en = 1'b1;
			push_idx = sp_step(st_q.sp, 1'b1);
			push_val = st_q.ret_addr;
		end
		else
		begin
			case (st_q.instr)
				OP_PUSH_SR:
				begin
					st_d.sp = sp_step(st_q.sp, 1'b1);
					push_en = 1'b1;
					push_idx = sp_step(st_q.sp, 1'b1);
				end
				OP_POP_SR:
				begin
					st_d.sr = stack_q[st_q.sp];
					st_d.sp = sp_step(st_q.sp, 1'b0);
				end
				OP_READ_SR:
				begin
					st_d.dout = st_q.sr;
					st_d.dout_oe = 1'b1;
				end
				OP_WRITE_SR:
					st_d.sr = i_data;
				OP_WIDTH_FULL:
					st_d.sr[SR_WID_HI:SR_WID_LO] = WID_FULL;
				OP_WIDTH_TWELVE:
					st_d.sr[SR_WID_HI:SR_WID_LO] = WID_TWELVE;
				OP_WIDTH_BYTE:
					st_d.sr[SR_WID_HI:SR_WID_LO] = WID_BYTE;
				OP_HOLD_MODE:
					st_d.sr[SR_WID_HI:SR_WID_LO] = WID_HOLD;
				OP_DISABLE_INT:
					st_d.sr[SR_INT_DIS] = 1'b1;
				OP_ENABLE_INT:
					st_d.sr[SR_INT_DIS] = 1'b0;
				OP_CLEAR_INT:
				begin
					st_d.pend = i_irq;
					st_d.in_prog = 1'b0;
				end
				OP_IDLE:
				begin
					// a second idle right after is served as a plain step
					if (st_q.phase != SSO_IDLE)
					begin
						st_d.pc = st_q.pc;
						st_d.addr_oe = 1'b0;
						st_d.phase = SSO_IDLE;
					end
					else
						st_d.phase = SSO_AFTER;
				end
				default:
				begin
					if (st_q.instr[6:4] == OP_REL_JUMP_HI && (st_q.instr[1:0] == OP_REL_DATA_LO ||
						st_q.instr[1:0] == OP_REL_CALL_LO) && cond_met(st_q.instr[3:2], i_flag, st_q.sr[SR_SIGN]))
					begin
						st_d.pc = DW'(pc_inc + offset);
						st_d.addr = DW'(pc_inc + offset);
					end
				end
			endcase
			if (live != '0 && !st_q.sr[SR_INT_DIS] && !st_q.in_prog)
			begin
				st_d.in_prog = 1'b1;
				// clear only the taken request; ones arriving this cycle stay latched
				st_d.pend = st_d.pend & ~(live & ~(live - 1'b1));
				if (st_d.addr_oe && i_vector_valid)
				begin
					st_d.ret_addr = st_d.pc;
					st_d.pc = i_vector;
					st_d.addr = i_vector;
					st_d.svc_first = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_q <= '{instr: OP_NOP, pc: PC_RESET, sr: SR_RESET, sp: SP_RESET, pend: '0, in_prog: 1'b0,
				svc_first: 1'b0, ret_addr: '0, phase: SSO_RUN, addr: PC_RESET, addr_oe: 1'b1,
				dout: '0, dout_oe: 1'b0};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// the stack holds no reset: contents are undefined until pushed
	always_ff @(posedge i_ref_clk)
	begin
		if (push_en)
		begin
			stack_q[push_idx] <= push_val;
		end
	end

	assign o_data = st_q.dout;
	assign o_data_oe = st_q.dout_oe;
	assign o_addr = st_q.addr;
	assign o_addr_oe = st_q.addr_oe;
	assign o_in_progress = st_q.in_prog;
	assign o_status = st_q.sr;
	assign o_stack_ptr = st_q.sp;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	AST_PUSH_SP: assert property (st_q.instr == OP_PUSH_SR && !st_q.svc_first |=>
		o_stack_ptr == SPW'($past(o_stack_ptr) + 1'b1))
		else $error("push did not bump pointer");
	AST_POP_SP: assert property (st_q.instr == OP_POP_SR && !st_q.svc_first |=>
		o_stack_ptr == SPW'($past(o_stack_ptr) - 1'b1))
		else $error("pop did not drop pointer");
	AST_READ: assert property (st_q.instr == OP_READ_SR && !st_q.svc_first |=>
		o_data_oe && o_data == $past(o_status))
		else $error("status not driven on data port");
	AST_WRITE: assert property (st_q.instr == OP_WRITE_SR && !st_q.svc_first |=>
		o_status == $past(i_data))
		else $error("status not loaded from data");
	AST_NOP: assert property (st_q.instr == OP_NOP && !st_q.svc_first && live == '0 |=>
		o_addr == DW'($past(st_q.pc) + 1'b1) && $stable(o_status) && $stable(o_stack_ptr))
		else $error("no-op changed state");
	AST_TWELVE: assert property (st_q.instr == OP_WIDTH_TWELVE && !st_q.svc_first |=>
		o_status[5:4] == WID_TWELVE)
		else $error("twelve width not set");
	AST_HOLD: assert property (st_q.instr == OP_HOLD_MODE && !st_q.svc_first |=>
		o_status[5:4] == WID_HOLD)
		else $error("hold mode not set");
	AST_EXT_BYTE: assert property (st_q.sr[SR_WID_HI:SR_WID_LO] == WID_BYTE |->
		offset[15:8] == {8{i_data[7]}})
		else $error("byte offset not sign extended");
	AST_IDLE: assert property (st_q.instr == OP_IDLE && st_q.phase != SSO_IDLE && !st_q.svc_first |=>
		!o_addr_oe && st_q.pc == $past(st_q.pc) ##1 o_addr_oe)
		else $error("idle did not float for exactly one cycle");
	AST_IDLE_PAIR: assert property (!o_addr_oe |=> o_addr_oe)
		else $error("address port floated two cycles running");
	AST_IDLE_INT: assert property (st_q.instr == OP_IDLE && st_q.phase != SSO_IDLE && live != '0 &&
		!st_q.svc_first && !st_q.sr[SR_INT_DIS] && !st_q.in_prog |=> o_in_progress && !o_addr_oe && !st_q.svc_first)
		else $error("interrupt during idle mishandled");
	AST_PEND: assert property (i_irq != '0 && st_q.instr != OP_CLEAR_INT |=>
		(st_q.pend & $past(i_irq)) == $past(i_irq) || $rose(st_q.in_prog))
		else $error("request lost");

	COV_IDLE: cover property (st_q.phase == SSO_IDLE);
	COV_PUSH_POP: cover property (st_q.instr == OP_PUSH_SR ##[1:8] st_q.instr == OP_POP_SR);
	COV_SERVICE: cover property (st_q.svc_first);
	COV_IDLE_INT: cover property (st_q.phase == SSO_IDLE && o_in_progress);
endmodule : sso_core

/* File: dv/sso_bus_model.sv */
`timescale 1ns/1ps
module sso_bus_model
	import sso_pkg::*;
(
	input  wire logic          i_ref_clk,
	input  wire logic [DW-1:0] i_seq_data,
	input  wire logic          i_seq_data_oe,
	input  wire logic          i_drive,
	input  wire logic [DW-1:0] i_drive_val,
	output logic [DW-1:0]      o_bus
);
	logic [DW-1:0] last_q = '0;
	always_comb
	begin
		if (i_seq_data_oe)
			o_bus = i_seq_data;
		else if (i_drive)
			o_bus = i_drive_val;
		else
			o_bus = ~last_q; // released bus toggles so a stale value never looks valid
	end
	always_ff @(posedge i_ref_clk)
		last_q <= o_bus;
endmodule : sso_bus_model

/* File: dv/test_sequencer_status_offset_misc_ops.sv */
`timescale 1ns/1ps
module test_sequencer_status_offset_misc_ops;
	import sso_pkg::*;
	logic               i_ref_clk = 1'b0;
	logic               i_nrst    = 1'b0;
	logic [OPW-1:0]     i_instr   = OP_NOP;
	logic [NUM_IRQ-1:0] i_irq     = '0;
	logic               i_flag    = 1'b0;
	logic               drive     = 1'b0;
	logic [DW-1:0]      drive_val = '0;
	logic [DW-1:0]      i_data, o_data, o_addr, o_status, a0, sr, v;
	logic               o_data_oe, o_addr_oe, o_in_progress;
	logic [SPW-1:0]     o_stack_ptr, sp0;
	logic [OPW-1:0]     ops [4]   = '{OP_WIDTH_FULL, OP_WIDTH_TWELVE, OP_HOLD_MODE, OP_WIDTH_BYTE};
	logic [1:0]         codes [4] = '{WID_FULL, WID_TWELVE, WID_HOLD, WID_BYTE};
	int                 n_errors = 0, comparisons = 0, seed = 14, k, j;
	sso_core #(.DEPTH(STACK_DEPTH)) uut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_instr(i_instr),
		.i_data(i_data), .i_irq(i_irq), .i_vector_valid(1'b1), .i_vector(16'h0040), .i_flag(i_flag),
		.o_data(o_data), .o_data_oe(o_data_oe), .o_addr(o_addr), .o_addr_oe(o_addr_oe),
		.o_in_progress(o_in_progress), .o_status(o_status), .o_stack_ptr(o_stack_ptr));
	sso_bus_model bus (.i_ref_clk(i_ref_clk), .i_seq_data(o_data), .i_seq_data_oe(o_data_oe),
		.i_drive(drive), .i_drive_val(drive_val), .o_bus(i_data));
	initial
		forever #50 i_ref_clk = ~i_ref_clk;
	task automatic chk16(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk16
	task automatic chk1(input string nm, input logic e, input logic g);
		chk16(nm, {15'h0, e}, {15'h0, g});
	endtask : chk1
	task automatic conclude();
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	function automatic logic [DW-1:0] ext(input logic [1:0] w, input logic [DW-1:0] d);
		case (w)
			WID_FULL:   return d;
			WID_TWELVE: return {{4{d[11]}}, d[11:0]};
			default:    return {{8{d[7]}}, d[7:0]};
		endcase
	endfunction : ext
	// opcode is followed by a step so results are seen before the next opcode executes
	task automatic exec(input logic [OPW-1:0] op, input logic [DW-1:0] d, input logic drv);
		@(negedge i_ref_clk);
		i_instr = op;
		@(negedge i_ref_clk);
		i_instr   = OP_NOP;
		drive     = drv;
		drive_val = d;
		a0        = o_addr;
		sr        = o_status;
		sp0       = o_stack_ptr;
		@(negedge i_ref_clk);
		drive = 1'b0;
	endtask : exec
	initial
	begin
		repeat (6) @(negedge i_ref_clk);
		chk16("status", SR_RESET, o_status);
		chk16("addr", PC_RESET, o_addr);
		chk1("addr_oe", 1'b1, o_addr_oe);
		chk1("data_oe", 1'b0, o_data_oe);
		chk1("in_progress", 1'b0, o_in_progress);
		chk16("stack_ptr", {12'h0, SP_RESET}, {12'h0, o_stack_ptr});
		i_nrst = 1'b1;
		i_irq  = 10'h008;
		exec(OP_NOP, 16'h0, 1'b0);
		i_irq = '0;
		chk1("in_progress", 1'b0, o_in_progress);
		exec(OP_WRITE_SR, 16'h0000, 1'b1);
		for (k = 0; k < 8 && o_in_progress !== 1'b1; k++)
			@(negedge i_ref_clk);
		chk1("in_progress", 1'b1, o_in_progress);
		if (o_in_progress !== 1'b1)
			conclude();
		exec(OP_NOP, 16'h0, 1'b0);
		chk16("stack_ptr", {12'h0, SP_RESET + 4'h1}, {12'h0, o_stack_ptr});
		exec(OP_CLEAR_INT, 16'h0, 1'b0);
		chk1("in_progress", 1'b0, o_in_progress);
		for (k = 0; k < 6; k++)
		begin
			v    = $random(seed);
			v[2] = 1'b1; // interrupts stay off so no vector disturbs the address checks
			exec(OP_WRITE_SR, v, 1'b1);
			chk16("status", v, o_status);
			exec(OP_READ_SR, 16'h0, 1'b0);
			chk1("data_oe", 1'b1, o_data_oe);
			chk16("data", v, o_data);
			chk16("addr", a0 + 16'h1, o_addr);
		end
		exec(OP_PUSH_SR, 16'h0, 1'b0);
		chk16("stack_ptr", {12'h0, sp0 + 4'h1}, {12'h0, o_stack_ptr});
		chk16("addr", a0 + 16'h1, o_addr);
		exec(OP_WRITE_SR, 16'h1234, 1'b1);
		exec(OP_NOP, 16'h0, 1'b0);
		chk16("status", sr, o_status);
		chk16("stack_ptr", {12'h0, sp0}, {12'h0, o_stack_ptr});
		chk16("addr", a0 + 16'h1, o_addr);
		exec(OP_POP_SR, 16'h0, 1'b0);
		chk16("status", v, o_status);
		chk16("stack_ptr", {12'h0, sp0 - 4'h1}, {12'h0, o_stack_ptr});
		for (k = 0; k < 4; k++)
		begin
			exec(ops[k], 16'h0, 1'b0);
			chk16("status", {sr[15:6], codes[k], sr[3:0]}, o_status);
			for (j = 0; j < 2; j++)
			begin
				v      = $random(seed);
				i_flag = ~j[0];
				exec({3'b111, 2'b10, OP_REL_DATA_LO}, v, 1'b1);
				chk16("addr", a0 + 16'h1 + (i_flag ? ext(codes[k], v) : 16'h0), o_addr);
				chk16("status", sr, o_status);
			end
		end
		@(negedge i_ref_clk);
		i_instr = OP_IDLE;
		@(negedge i_ref_clk);
		a0 = o_addr;
		@(negedge i_ref_clk);
		i_instr = OP_NOP;
		chk1("addr_oe", 1'b0, o_addr_oe);
		@(negedge i_ref_clk);
		chk1("addr_oe", 1'b1, o_addr_oe);
		chk16("addr", a0 + 16'h1, o_addr);
		exec(OP_IDLE, 16'h0, 1'b0);
		chk1("addr_oe", 1'b0, o_addr_oe);
		exec(OP_WRITE_SR, 16'h0000, 1'b1);
		exec(OP_DISABLE_INT, 16'h0, 1'b0);
		chk16("status", 16'h0004, o_status);
		i_irq = 10'h006;
		exec(OP_NOP, 16'h0, 1'b0);
		i_irq = '0;
		chk1("in_progress", 1'b0, o_in_progress);
		// enable right before idle so the request is taken in the idle cycle
		@(negedge i_ref_clk);
		i_instr = OP_ENABLE_INT;
		@(negedge i_ref_clk);
		i_instr = OP_IDLE;
		@(negedge i_ref_clk);
		i_instr = OP_NOP;
		a0 = o_addr;
		@(negedge i_ref_clk);
		chk1("in_progress", 1'b1, o_in_progress);
		chk1("addr_oe", 1'b0, o_addr_oe);
		@(negedge i_ref_clk);
		chk1("addr_oe", 1'b1, o_addr_oe);
		chk16("addr", a0 + 16'h1, o_addr);
		chk1("in_progress", 1'b1, o_in_progress);
		conclude();
	end
endmodule : test_sequencer_status_offset_misc_ops
